// ==== design/txd_pkg.sv ====
/*
 * Shared constants for the transmit descriptor handler: descriptor word
 * field positions, state codes and reset values.
 * Assumes one clock domain and that descriptor words arrive already
 * fetched from system memory by the bus master path.
 */
// Behaviour
// - Buffer address is high byte of word 1 above low word 0.
// - Any buffer alignment and length accepted; no address checks.
// - Word 1 bit 15 ownership: host sets, device clears after sending.
// - Neither party alters an entry after handing over ownership.
// - Bit 14 fault summary is OR of four transmit fault flags.
// - Fault summary goes into whichever descriptor is current at fault.
// - Bit 13 in first buffer forces FCS, ignoring global disable.
// - Without forcing, global disable setting decides FCS generation.
// - Bit 10 waited flag set when channel busy at ready time.
// - Owned descriptors lacking first buffer flag are skipped while hunting.
// - First and last both set means single buffer frame, no chaining.
// - Device never writes the first buffer flag.
// - Bits 7..0 high address byte are only read by the device.
// - Single retry flag set on exactly one retry, invalid on late collision.
package txd_pkg;

    localparam int unsigned WORD_W      = 16;
    localparam int unsigned ADDR_W      = 24;

    localparam int unsigned BIT_OWN     = 15;
    localparam int unsigned BIT_FAULT   = 14;
    localparam int unsigned BIT_FORCE   = 13;
    localparam int unsigned BIT_ONE     = 11;
    localparam int unsigned BIT_WAITED  = 10;
    localparam int unsigned BIT_FIRST   = 9;
    localparam int unsigned BIT_LAST    = 8;
    localparam int unsigned HIGH_MSB    = 7;
    localparam int unsigned HIGH_LSB    = 0;

    localparam logic [15:0] WORD_RST    = 16'h0000;
    localparam logic [23:0] ADDR_RST    = 24'h00_0000;

    typedef enum logic [3:0] {
        TXD_HUNT  = 4'b0001,
        TXD_SEND  = 4'b0010,
        TXD_WB    = 4'b0100,
        TXD_CHAIN = 4'b1000
    } txd_state_e;

endpackage

// ==== design/txd_wb_if.sv ====
/*
 * Carrier between the descriptor controller and the write-back composer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface txd_wb_if;
    logic        load;
    logic [15:0] word_in;
    logic        fault;
    logic        waited;
    logic        one_retry;
    logic        final_buf;
    logic [15:0] word_out;

    modport ctrl (output load, output word_in, output fault, output waited,
                  output one_retry, output final_buf, input word_out);
    modport comp (input load, input word_in, input fault, input waited,
                  input one_retry, input final_buf, output word_out);
endinterface

// ==== design/txd_wb.sv ====
/*
 * Write-back composer: builds the returned status word of a descriptor
 * from the fetched word and the collected status, in one register.
 * Assumes load is a one-cycle pulse on the shared clock.
 */
`timescale 1ns/10ps
module txd_wb
    import txd_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    txd_wb_if.comp    wb
);

    logic [15:0] next_word;

    always_comb begin
        next_word = wb.word_in;
        next_word[BIT_OWN] = 1'b0;
        next_word[BIT_FAULT] = wb.fault;
        next_word[BIT_WAITED] = wb.final_buf & wb.waited;
        next_word[BIT_ONE] = wb.final_buf & wb.one_retry;
        // First, last, force and high address pass unchanged
        next_word[BIT_FIRST] = wb.word_in[BIT_FIRST];
        next_word[HIGH_MSB:HIGH_LSB] = wb.word_in[HIGH_MSB:HIGH_LSB];
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wb.word_out <= WORD_RST;
        end else if (wb.load) begin
            wb.word_out <= next_word;
        end
    end

endmodule

// ==== design/txd_ctrl.sv ====
/*
 * Transmit descriptor controller: checks ownership and chaining flags of
 * fetched descriptors, hands buffer address and FCS choice to the
 * transmit path, collects fault status and returns the descriptor.
 * Assumes descriptor words, buffer completion and fault events come from
 * logic on the same clock; ring pointer and memory access live outside.
 */
`timescale 1ns/10ps
module txd_ctrl
    import txd_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_desc_valid,
    input  wire logic [15:0] i_desc_word0,
    input  wire logic [15:0] i_desc_word1,
    input  wire logic        i_disable_tx_checksum,
    input  wire logic        i_buf_done,
    input  wire logic        i_underrun,
    input  wire logic        i_late_collision,
    input  wire logic        i_carrier_lost,
    input  wire logic        i_retry_exhausted,
    input  wire logic        i_deferred,
    input  wire logic        i_one_retry,
    input  wire logic        i_wb_ready,
    output logic             o_next_desc,
    output logic             o_repoll,
    output logic             o_buf_start,
    output logic [23:0]      o_buf_addr,
    output logic             o_fcs_enable,
    output logic             o_frame_first,
    output logic             o_frame_last,
    output logic             o_wb_valid,
    output logic [15:0]      o_wb_word1,
    output logic             o_busy
);

    txd_wb_if wb ();

    txd_state_e  state;
    txd_state_e  next_state;
    logic [15:0] cur_word1;
    logic        fault_buf;
    logic        waited_frame;
    logic        one_frame;
    logic        late_frame;

    // Field decoding of the incoming descriptor
    wire owned      = i_desc_word1[BIT_OWN];
    wire first_flag = i_desc_word1[BIT_FIRST];
    wire last_flag  = i_desc_word1[BIT_LAST];
    wire force_fcs  = i_desc_word1[BIT_FORCE];
    wire fault_now  = i_underrun | i_late_collision
                    | i_carrier_lost | i_retry_exhausted;

    wire in_hunt    = (state == TXD_HUNT);
    wire in_send    = (state == TXD_SEND);
    wire in_wb      = (state == TXD_WB);
    wire in_chain   = (state == TXD_CHAIN);

    // Frame start needs both ownership and first buffer flags
    wire take_first = in_hunt & i_desc_valid & owned & first_flag;
    wire skip_desc  = in_hunt & i_desc_valid & owned & ~first_flag;
    wire hunt_wait  = in_hunt & i_desc_valid & ~owned;
    wire take_chain = in_chain & i_desc_valid & owned;
    wire chain_wait = in_chain & i_desc_valid & ~owned;
    wire take_any   = take_first | take_chain;

    // Buffer address from high byte above low word, no alignment check
    wire [23:0] addr_now = {i_desc_word1[HIGH_MSB:HIGH_LSB],
                            i_desc_word0};

    // Per-frame FCS decision, taken from the first buffer only
    wire fcs_now = force_fcs ? 1'b1 : ~i_disable_tx_checksum;

    wire fault_done = fault_buf | fault_now;
    wire wb_accept  = in_wb & i_wb_ready;
    wire buf_end    = in_send & i_buf_done;
    wire frame_end  = cur_word1[BIT_LAST] | wb.word_out[BIT_FAULT];

    always_comb begin
        next_state = state;
        case (state)
            TXD_HUNT: begin
                if (take_first) begin
                    next_state = TXD_SEND;
                end
            end
            TXD_SEND: begin
                if (i_buf_done) begin
                    next_state = TXD_WB;
                end
            end
            TXD_WB: begin
                if (i_wb_ready) begin
                    // Last buffer or fault ends the frame
                    next_state = frame_end ? TXD_HUNT : TXD_CHAIN;
                end
            end
            TXD_CHAIN: begin
                if (take_chain) begin
                    next_state = TXD_SEND;
                end
            end
            default: begin
                next_state = TXD_HUNT;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= TXD_HUNT;
        end else begin
            state <= next_state;
        end
    end

    // Capture the fetched word; it is not touched until write-back
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cur_word1 <= WORD_RST;
        end else if (take_any) begin
            cur_word1 <= i_desc_word1;
        end
    end

    // Fault summary of the current descriptor only
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fault_buf <= 1'b0;
        end else if (take_any) begin
            fault_buf <= 1'b0;
        end else if (in_send) begin
            fault_buf <= fault_done;
        end
    end

    // Frame-wide retry and deferral status
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            waited_frame <= 1'b0;
            one_frame    <= 1'b0;
            late_frame   <= 1'b0;
        end else if (take_first) begin
            waited_frame <= 1'b0;
            one_frame    <= 1'b0;
            late_frame   <= 1'b0;
        end else if (in_send) begin
            waited_frame <= waited_frame | i_deferred;
            one_frame    <= one_frame | i_one_retry;
            late_frame   <= late_frame | i_late_collision;
        end
    end

    // Composer load at buffer end, including a fault seen that cycle
    assign wb.load      = buf_end;
    assign wb.word_in   = cur_word1;
    assign wb.fault     = fault_done;
    assign wb.waited    = waited_frame | i_deferred;
    assign wb.one_retry = (one_frame | i_one_retry)
                        & ~(late_frame | i_late_collision);
    assign wb.final_buf = cur_word1[BIT_LAST] | fault_done;

    txd_wb i_txd_wb (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .wb    (wb)
    );

    assign o_wb_word1 = wb.word_out;

    // Ring steering pulses
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_next_desc <= 1'b0;
            o_repoll    <= 1'b0;
        end else begin
            o_next_desc <= skip_desc | wb_accept;
            o_repoll    <= hunt_wait | chain_wait;
        end
    end

    // Buffer hand-off pulse and frame activity
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_buf_start <= 1'b0;
            o_busy      <= 1'b0;
        end else begin
            o_buf_start <= take_any;
            o_busy      <= (next_state != TXD_HUNT);
        end
    end

    // Write-back request stands until accepted
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wb_valid <= 1'b0;
        end else begin
            o_wb_valid <= buf_end | (in_wb & ~i_wb_ready);
        end
    end

    // Buffer steering stands until the next hand-off
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_buf_addr    <= ADDR_RST;
            o_frame_first <= 1'b0;
            o_frame_last  <= 1'b0;
        end else if (take_any) begin
            o_buf_addr    <= addr_now;
            o_frame_first <= take_first;
            o_frame_last  <= last_flag;
        end
    end

    // FCS choice made once per frame, at its first buffer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_fcs_enable <= 1'b0;
        end else if (take_first) begin
            o_fcs_enable <= fcs_now;
        end
    end

endmodule

// ==== testbench/txd_ctrl_sva.sv ====
/* Port checker for the descriptor controller.
   Assumes one clock and that fetched words only change with a fetch. */
`timescale 1ns/10ps
module txd_ctrl_sva
    import txd_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_desc_valid,
    input wire logic [15:0] i_desc_word0,
    input wire logic [15:0] i_desc_word1,
    input wire logic        i_disable_tx_checksum,
    input wire logic        i_underrun,
    input wire logic        i_late_collision,
    input wire logic        i_carrier_lost,
    input wire logic        i_retry_exhausted,
    input wire logic        i_deferred,
    input wire logic        i_wb_ready,
    input wire logic        o_next_desc,
    input wire logic        o_repoll,
    input wire logic        o_buf_start,
    input wire logic [23:0] o_buf_addr,
    input wire logic        o_fcs_enable,
    input wire logic        o_frame_first,
    input wire logic        o_frame_last,
    input wire logic        o_wb_valid,
    input wire logic [15:0] o_wb_word1,
    input wire logic        o_busy
);
    logic [15:0] w1;
    logic        flt;
    logic        late_seen;
    logic        dfr;
    wire logic   any_flt = i_underrun | i_late_collision | i_carrier_lost
                           | i_retry_exhausted;
    wire logic   hunt = i_desc_valid & ~o_busy & i_desc_word1[15];
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Fetched word, faults since the buffer started, late and deferral since the frame started
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            {w1, flt, late_seen, dfr} <= 19'h0_0000;
        end else begin
            w1   <= i_desc_valid ? i_desc_word1 : w1;
            flt  <= (o_buf_start ? 1'b0 : flt) | any_flt;
            late_seen <= (o_buf_start && o_frame_first ? 1'b0 : late_seen)
                         | i_late_collision;
            dfr  <= (o_buf_start && o_frame_first ? 1'b0 : dfr) | i_deferred;
        end
    end
    addr_join_a: assert property (o_buf_start |->
        o_buf_addr == {$past(i_desc_word1[7:0]), $past(i_desc_word0)})
        else $error("buffer address not joined from fetched words");
    own_return_a: assert property (o_wb_valid |-> !o_wb_word1[15])
        else $error("write-back keeps ownership");
    host_bits_a: assert property (o_wb_valid |->
        {o_wb_word1[13:12], o_wb_word1[9:0]} == {w1[13:12], w1[9:0]})
        else $error("host bits altered");
    fault_sum_a: assert property ($rose(o_wb_valid) |->
        o_wb_word1[14] == flt) else $error("fault summary wrong");
    waited_flag_a: assert property ($rose(o_wb_valid) &&
        (o_wb_word1[8] || o_wb_word1[14]) |-> o_wb_word1[10] == dfr)
        else $error("waited flag wrong");
    one_late_a: assert property ($rose(o_wb_valid) && late_seen |->
        !o_wb_word1[11]) else $error("single retry with late collision");
    fcs_force_a: assert property (hunt && i_desc_word1[9] &&
        i_desc_word1[13] |=> o_fcs_enable) else $error("forced FCS lost");
    fcs_global_a: assert property (hunt && i_desc_word1[9] &&
        !i_desc_word1[13] |=> o_fcs_enable == !$past(i_disable_tx_checksum))
        else $error("FCS ignores global disable");
    skip_start_a: assert property (hunt && !i_desc_word1[9] |=>
        o_next_desc && !o_buf_start) else $error("unstarted entry used");
    single_buf_a: assert property (hunt && i_desc_word1[9:8] == 2'b11
        |=> o_frame_first && o_frame_last) else $error("single buffer");
    wb_done_a: assert property (o_wb_valid && i_wb_ready |=>
        o_next_desc && !o_wb_valid) else $error("write-back not closed");
    cover property (o_repoll);
    cover property (o_wb_valid && !i_wb_ready);
    cover property (o_buf_start && !o_frame_first);
endmodule
bind txd_ctrl txd_ctrl_sva i_txd_ctrl_sva (.*);

// ==== testbench/txd_host.sv ====
/* Host model: a ring of eight descriptors handed out on request, with
   write-back accepted at a varying pace. Assumes the bench fills it. */
`timescale 1ns/10ps
module txd_host (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_next_desc,
    input  wire logic        i_repoll,
    input  wire logic        i_wb_valid,
    input  wire logic [15:0] i_wb_word1,
    output logic             o_desc_valid,
    output logic [15:0]      o_desc_word0,
    output logic [15:0]      o_desc_word1,
    output logic             o_wb_ready
);
    logic [15:0] ring0 [8];
    logic [15:0] ring1 [8];
    logic [2:0]  idx;
    logic [2:0]  wait_n;
    logic [2:0]  tick;
    // Idle bus shows the inverse, never the last value
    assign o_desc_word0 = o_desc_valid ? ring0[idx] : ~ring0[idx];
    assign o_desc_word1 = o_desc_valid ? ring1[idx] : ~ring1[idx];
    always @(negedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            {idx, wait_n, tick, o_desc_valid, o_wb_ready} <= 11'h060;
        end else begin
            tick         <= tick + 3'h1;
            o_wb_ready   <= tick[1];
            o_desc_valid <= wait_n == 3'h1;
            if (i_next_desc) begin
                idx    <= idx + 3'h1;
                wait_n <= 3'h3;
            end else if (i_repoll) begin
                wait_n <= 3'h6;
            end else if (wait_n != 3'h0) begin
                wait_n <= wait_n - 3'h1;
            end
        end
    end
    // Entry is touched again only once handed back
    always @(posedge i_clk) begin
        if (i_wb_valid && o_wb_ready) begin
            ring1[idx] <= i_wb_word1;
        end
    end
endmodule

// ==== testbench/txd_ctrl_tb.sv ====
/* Self-checking bench for the descriptor controller driven by the host
   model, with fault and retry status injected per buffer. */
`timescale 1ns/10ps
module txd_ctrl_tb;
    import txd_pkg::*;
    logic i_clk, i_rst, i_desc_valid, i_disable_tx_checksum, i_buf_done;
    logic i_underrun, i_late_collision, i_carrier_lost, i_retry_exhausted;
    logic i_deferred, i_one_retry, i_wb_ready, o_next_desc, o_repoll;
    logic o_buf_start, o_fcs_enable, o_frame_first, o_frame_last, o_busy;
    logic o_wb_valid, wb_prev, fcs;
    logic [15:0] i_desc_word0, i_desc_word1, o_wb_word1, w;
    logic [23:0] o_buf_addr;
    logic [24:0] e;
    logic [5:0]  a;
    logic [24:0] q_s [$];
    logic [15:0] q_w [$];
    logic [5:0]  acts [$];
    int          n_errors, compares, n_rep, cyc, k, seed;
    logic [15:0] w1_t [8] = '{16'h8300, 16'h8100, 16'ha300, 16'h8200,
                              16'h8200, 16'h8100, 16'h8300, 16'h8300};
    logic [5:0]  act_t [8] = '{6'h00, 6'h00, 6'h10, 6'h01,
                               6'h00, 6'h32, 6'h24, 6'h08};
    txd_ctrl i_txd_ctrl (.*);
    txd_host i_txd_host (.i_clk(i_clk), .i_rst(i_rst),
        .i_next_desc(o_next_desc), .i_repoll(o_repoll),
        .i_wb_valid(o_wb_valid), .i_wb_word1(o_wb_word1),
        .o_desc_valid(i_desc_valid), .o_desc_word0(i_desc_word0),
        .o_desc_word1(i_desc_word1), .o_wb_ready(i_wb_ready));
    // Status bits: one retry, waited, exhausted, carrier, late, underrun
    function automatic logic [15:0] exp_wb(logic [15:0] v, logic [5:0] s);
        exp_wb = v & 16'h7fff;
        exp_wb[14] = |s[3:0];
        exp_wb[10] = (v[8] | exp_wb[14]) & s[4];
        exp_wb[11] = (v[8] | exp_wb[14]) & s[5] & ~s[1];
    endfunction
    task automatic check(string what, logic [24:0] seen, logic [24:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    always @(negedge i_clk) begin
        if (!i_rst && o_buf_start) begin
            e = q_s.size() ? q_s.pop_front() : 'x;
            check("start", {o_buf_addr, o_fcs_enable}, e);
        end
        if (o_wb_valid && !wb_prev) begin
            e = q_w.size() ? {9'h000, q_w.pop_front()} : 'x;
            check("wb", o_wb_word1, e);
        end
        wb_prev = o_wb_valid;
        n_rep   = n_rep + int'(o_repoll);
    end
    initial begin
        {i_rst, i_disable_tx_checksum, wb_prev, fcs} = 4'b1000;
        {i_buf_done, i_one_retry, i_deferred, i_retry_exhausted} = 4'h0;
        {i_carrier_lost, i_late_collision, i_underrun} = 3'h0;
        seed = 32'h248f;
        for (k = 0; k < 8; k++) begin
            w = w1_t[k] | {8'h00, 8'($random(seed))};
            i_txd_host.ring0[k] = 16'($random(seed));
            i_txd_host.ring1[k] = w;
            if (w[9]) fcs = w[13] | ~k[1];
            if (k != 1) begin
                q_s.push_back({w[7:0], i_txd_host.ring0[k], fcs});
                q_w.push_back(exp_wb(w, act_t[k]));
                acts.push_back(act_t[k]);
            end
        end
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        forever begin
            @(negedge i_clk);
            // Global disable follows bit 1 of the ring index
            i_disable_tx_checksum = i_txd_host.idx[1];
            if (o_buf_start) begin
                a = acts.pop_front();
                repeat (2) @(negedge i_clk);
                {i_one_retry, i_deferred, i_retry_exhausted} = a[5:3];
                {i_carrier_lost, i_late_collision, i_underrun} = a[2:0];
                i_buf_done = 1'b1;
                @(negedge i_clk);
                {i_one_retry, i_deferred, i_retry_exhausted} = 3'h0;
                {i_carrier_lost, i_late_collision, i_underrun} = 3'h0;
                i_buf_done = 1'b0;
            end
            if (q_w.size() == 0 && n_rep >= 3) begin
                check("idle", {o_busy, q_s.size() == 0}, 25'h1);
                stop_test();
            end
        end
    end
endmodule
